// [logic/skip_branch_control.v]
// skip and relative-jump control for the core program counter
`timescale 1ns/1ps
`include "skip_branch_consts.vh"
module skip_branch_control (
  input wire core_clk,
  input wire rstn,
  input wire op_valid,
  input wire [4:0] op_sel,
  input wire [2:0] bit_index,
  input wire [7:0] reg_value,
  input wire [7:0] io_value,
  input wire [7:0] flag_register,
  input wire [6:0] jump_offset,
  input wire next_is_two_word,
  output reg [15:0] pc,
  output reg taken,
  output reg busy,
  output reg done
);
  // sequencer states: idle, or extra cycles still to burn
  localparam [1:0] ST_IDLE = 2'h0; // ready for an op
  localparam [1:0] ST_LAST = 2'h1; // one extra cycle left
  localparam [1:0] ST_FIRST = 2'h2; // first of two extra cycles
  // selected bits from each source
  wire reg_bit; // tested bit of the general register
  wire io_bit; // tested bit of the io register
  wire flag_bit; // flag chosen by the index
  // decision of the current op
  reg cond; // the op's condition holds
  reg is_skip; // op is one of the skips
  reg is_jump; // op is one of the relative jumps
  // sign-extended word displacement
  wire [15:0] offset_ext;
  // candidate program counter values
  wire [15:0] step_pc; // plain advance to the next word
  wire [15:0] skip_short_pc; // past a one-word follower
  wire [15:0] skip_long_pc; // past a two-word follower
  wire [15:0] jump_pc; // relative jump target
  // handshake and outcome of the op
  wire accept; // op taken at this edge
  wire skip_hit; // a skip whose condition holds
  wire jump_hit; // a jump whose condition holds
  wire hit; // control flow changes
  wire long_skip; // skip over a two-word follower
  // sequencer state and its next value
  reg [1:0] state;
  reg [1:0] next_state;
  // next values of the registered outputs
  reg [15:0] next_pc;
  reg next_taken;
  reg next_busy;
  reg next_done;

  // tested bit of the general register
  bit_pick pick_reg (
    .word(reg_value),
    .index(bit_index),
    .bit_value(reg_bit)
  );

  // tested bit of the io register
  bit_pick pick_io (
    .word(io_value),
    .index(bit_index),
    .bit_value(io_bit)
  );

  // flag chosen by the index
  bit_pick pick_flag (
    .word(flag_register),
    .index(bit_index),
    .bit_value(flag_bit)
  );

  // offset is signed words, may reach back
  assign offset_ext = {{9{jump_offset[6]}}, jump_offset};

  // candidate targets, all cut to the 16-bit counter
  assign step_pc = pc + `PC_STEP_ONE;
  assign skip_short_pc = pc + `PC_STEP_SKIP_SHORT;
  assign skip_long_pc = pc + `PC_STEP_SKIP_LONG;
  assign jump_pc = pc + offset_ext + `PC_STEP_ONE;

  // condition decode per operation
  always @* begin
    cond = 1'b0;
    is_skip = 1'b0;
    is_jump = 1'b0;
    case (op_sel)
      // register bit zero skips
      `OP_SKIP_IF_REG_BIT_CLEAR: begin
        is_skip = 1'b1;
        cond = ~reg_bit;
      end

      // register bit one skips
      `OP_SKIP_IF_REG_BIT_SET: begin
        is_skip = 1'b1;
        cond = reg_bit;
      end

      // io bit zero skips
      `OP_SKIP_IF_IO_BIT_CLEAR: begin
        is_skip = 1'b1;
        cond = ~io_bit;
      end

      // io bit one skips
      `OP_SKIP_IF_IO_BIT_SET: begin
        is_skip = 1'b1;
        cond = io_bit;
      end

      // indexed flag one jumps
      `OP_JUMP_IF_INDEXED_FLAG_SET: begin
        is_jump = 1'b1;
        cond = flag_bit;
      end

      // indexed flag zero jumps
      `OP_JUMP_IF_INDEXED_FLAG_CLEAR: begin
        is_jump = 1'b1;
        cond = ~flag_bit;
      end

      // zero flag one jumps
      `OP_JUMP_IF_EQUAL: begin
        is_jump = 1'b1;
        cond = flag_register[`FLAG_Z];
      end

      // zero flag zero jumps
      `OP_JUMP_IF_UNEQUAL: begin
        is_jump = 1'b1;
        cond = ~flag_register[`FLAG_Z];
      end

      // carry one jumps
      `OP_JUMP_IF_CARRY_ONE: begin
        is_jump = 1'b1;
        cond = flag_register[`FLAG_C];
      end

      // carry zero jumps
      `OP_JUMP_IF_CARRY_ZERO: begin
        is_jump = 1'b1;
        cond = ~flag_register[`FLAG_C];
      end

      // unsigned at least: carry zero jumps
      `OP_JUMP_IF_UNSIGNED_AT_LEAST: begin
        is_jump = 1'b1;
        cond = ~flag_register[`FLAG_C];
      end

      // unsigned below: carry one jumps
      `OP_JUMP_IF_UNSIGNED_BELOW: begin
        is_jump = 1'b1;
        cond = flag_register[`FLAG_C];
      end

      // negative one jumps
      `OP_JUMP_IF_NEGATIVE: begin
        is_jump = 1'b1;
        cond = flag_register[`FLAG_N];
      end

      // negative zero jumps
      `OP_JUMP_IF_NONNEGATIVE: begin
        is_jump = 1'b1;
        cond = ~flag_register[`FLAG_N];
      end

      // negative xor overflow zero jumps
      `OP_JUMP_IF_SIGNED_AT_LEAST: begin
        is_jump = 1'b1;
        cond = ~(flag_register[`FLAG_N] ^ flag_register[`FLAG_V]);
      end

      // half carry one jumps
      `OP_JUMP_IF_HALF_CARRY_ONE: begin
        is_jump = 1'b1;
        cond = flag_register[`FLAG_H];
      end

      // half carry zero jumps
      `OP_JUMP_IF_HALF_CARRY_ZERO: begin
        is_jump = 1'b1;
        cond = ~flag_register[`FLAG_H];
      end
      default: begin
        cond = 1'b0;
      end
    endcase
  end

  // an op is taken only while the sequencer is idle
  assign accept = op_valid & (state == ST_IDLE);
  // which kind of op changes control flow
  assign skip_hit = is_skip & cond;
  assign jump_hit = is_jump & cond;
  assign hit = skip_hit | jump_hit;
  // a taken skip over a two-word follower costs two extra cycles
  assign long_skip = skip_hit & next_is_two_word;

  // next program counter, moved only when an op is accepted
  always @* begin
    next_pc = pc;
    if (accept) begin
      if (skip_hit) begin
        // skip over one or two words
        if (next_is_two_word) begin
          next_pc = skip_long_pc;
        end else begin
          next_pc = skip_short_pc;
        end
      end else if (jump_hit) begin
        // relative jump, pc plus offset plus one
        next_pc = jump_pc;
      end else begin
        // condition false or no op: fall through
        next_pc = step_pc;
      end
    end
  end

  // sequencer: idle, or burning the extra cycles of a taken op
  always @* begin
    next_state = ST_IDLE;
    case (state)
      ST_IDLE: begin
        if (accept && long_skip) begin
          // three cycles in all
          next_state = ST_FIRST;
        end else if (accept && hit) begin
          // two cycles in all
          next_state = ST_LAST;
        end else begin
          // one cycle, or nothing to do
          next_state = ST_IDLE;
        end
      end
      ST_FIRST: begin
        // first extra cycle of a long skip
        next_state = ST_LAST;
      end
      ST_LAST: begin
        // last extra cycle, back to idle
        next_state = ST_IDLE;
      end
      default: begin
        // unused code, recover to idle
        next_state = ST_IDLE;
      end
    endcase
  end

  // next values of taken, busy and done
  always @* begin
    next_taken = 1'b0;
    next_busy = 1'b0;
    next_done = 1'b0;
    case (state)
      ST_IDLE: begin
        // taken stands from accept until the op ends
        next_taken = accept & hit;
        next_busy = accept & hit;
        // a one-cycle op finishes at once
        next_done = accept & ~hit;
      end
      ST_FIRST: begin
        // still busy, taken held
        next_taken = taken;
        next_busy = 1'b1;
      end
      ST_LAST: begin
        // op ends now, taken held for this last cycle
        next_taken = taken;
        next_done = 1'b1;
      end
      default: begin
        // unused code, outputs quiet
        next_taken = 1'b0;
      end
    endcase
  end

  // registered outputs; flag register is only read, never written
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      // quiet at reset, pc at its start value
      state <= ST_IDLE;
      pc <= `PC_RESET;
      taken <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      // every register moves on every edge
      state <= next_state;
      pc <= next_pc;
      taken <= next_taken;
      busy <= next_busy;
      done <= next_done;
    end
  end
endmodule

// [logic/skip_branch_consts.vh]
// constants for the skip and relative-jump control block
// Notes on behaviour
// - register bit zero: skip next instruction
// - register bit one: skip, flags unchanged
// - io bit zero: skip, flags unchanged
// - io bit one: skip, flags unchanged
// - indexed flag one: jump by offset plus one
// - indexed flag zero: jump, flags unchanged
// - zero flag one: jump
// - zero flag zero: jump
// - carry one: jump
// - carry zero: jump
// - unsigned at least equals carry zero
// - negative one: jump
// - half carry one: jump
// - half carry zero: jump, flags unchanged
// - unsigned below equals carry one
// - negative zero: jump
// - negative xor overflow zero: jump
`ifndef SKIP_BRANCH_CONSTS_VH
`define SKIP_BRANCH_CONSTS_VH
// operation codes on op_sel
`define OP_NONE 5'h00
`define OP_SKIP_IF_REG_BIT_CLEAR 5'h01
`define OP_SKIP_IF_REG_BIT_SET 5'h02
`define OP_SKIP_IF_IO_BIT_CLEAR 5'h03
`define OP_SKIP_IF_IO_BIT_SET 5'h04
`define OP_JUMP_IF_INDEXED_FLAG_SET 5'h05
`define OP_JUMP_IF_INDEXED_FLAG_CLEAR 5'h06
`define OP_JUMP_IF_EQUAL 5'h07
`define OP_JUMP_IF_UNEQUAL 5'h08
`define OP_JUMP_IF_CARRY_ONE 5'h09
`define OP_JUMP_IF_CARRY_ZERO 5'h0A
`define OP_JUMP_IF_UNSIGNED_AT_LEAST 5'h0B
`define OP_JUMP_IF_UNSIGNED_BELOW 5'h0C
`define OP_JUMP_IF_NEGATIVE 5'h0D
`define OP_JUMP_IF_NONNEGATIVE 5'h0E
`define OP_JUMP_IF_SIGNED_AT_LEAST 5'h0F
`define OP_JUMP_IF_HALF_CARRY_ONE 5'h10
`define OP_JUMP_IF_HALF_CARRY_ZERO 5'h11
// flag register bit positions
`define FLAG_C 3'h0
`define FLAG_Z 3'h1
`define FLAG_N 3'h2
`define FLAG_V 3'h3
`define FLAG_H 3'h5
// program counter steps
`define PC_STEP_ONE 16'h0001
`define PC_STEP_SKIP_SHORT 16'h0002
`define PC_STEP_SKIP_LONG 16'h0003
`define PC_RESET 16'h0000
`endif

// [logic/bit_pick.v]
// one-of-eight bit selector, registered-free
`timescale 1ns/1ps
module bit_pick (
  input wire [7:0] word,
  input wire [2:0] index,
  output wire bit_value
);
  // select the indexed bit
  assign bit_value = word[index];
endmodule

// [test/skip_branch_control_props.sv]
// timing and step checker for the skip and jump control block
`timescale 1ns/1ps
`include "skip_branch_consts.vh"
module skip_branch_control_props (
  input wire core_clk,
  input wire rstn,
  input wire op_valid,
  input wire [4:0] op_sel,
  input wire [2:0] bit_index,
  input wire [7:0] reg_value,
  input wire [7:0] io_value,
  input wire [7:0] flag_register,
  input wire [6:0] jump_offset,
  input wire next_is_two_word,
  input wire [15:0] pc,
  input wire taken,
  input wire busy,
  input wire done
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  // accepted op, else none
  wire [4:0] op = (op_valid && !busy) ? op_sel : `OP_NONE;
  // skip length and jump distance
  wire [15:0] stp = next_is_two_word ? 16'h0003 : 16'h0002;
  wire [15:0] jmp = {{9{jump_offset[6]}}, jump_offset} + 16'h0001;
  wire fb = flag_register[bit_index];
  a_skip_reg_clr: assert property (
    op == `OP_SKIP_IF_REG_BIT_CLEAR && !reg_value[bit_index] |=> pc == $past(pc) + $past(stp))
    else $error("bad skip step");
  a_skip_reg_set: assert property (
    op == `OP_SKIP_IF_REG_BIT_SET && reg_value[bit_index] |=> taken && busy)
    else $error("skip not taken");
  a_skip_io_clr: assert property (
    op == `OP_SKIP_IF_IO_BIT_CLEAR && !io_value[bit_index] |=> pc == $past(pc) + $past(stp))
    else $error("bad io skip step");
  a_skip_io_long: assert property (
    op == `OP_SKIP_IF_IO_BIT_SET && io_value[bit_index] && next_is_two_word
    |=> busy [*2] ##1 done) else $error("long skip timing");
  a_flag_set_jump: assert property (
    op == `OP_JUMP_IF_INDEXED_FLAG_SET && fb |=> pc == $past(pc) + $past(jmp))
    else $error("bad jump target");
  a_flag_clr_fall: assert property (
    op == `OP_JUMP_IF_INDEXED_FLAG_CLEAR && fb |=> !taken && pc == $past(pc) + 16'h0001)
    else $error("bad fall through");
  a_equal_fall: assert property (
    op == `OP_JUMP_IF_EQUAL && !flag_register[1] |=> pc == $past(pc) + 16'h0001)
    else $error("equal fell wrong");
  a_unequal_jump: assert property (
    op == `OP_JUMP_IF_UNEQUAL && !flag_register[1] |=> taken && busy ##1 done && !busy)
    else $error("jump timing");
  a_signed_ge: assert property (
    op == `OP_JUMP_IF_SIGNED_AT_LEAST && !(flag_register[2] ^ flag_register[3]) |=> taken)
    else $error("signed jump missed");
  c_long_skip: cover property (busy ##1 busy);
  c_index_jump: cover property (op == `OP_JUMP_IF_INDEXED_FLAG_SET && fb);
  c_signed: cover property (op == `OP_JUMP_IF_SIGNED_AT_LEAST);
endmodule
bind skip_branch_control skip_branch_control_props props (.core_clk, .rstn, .op_valid,
  .op_sel, .bit_index, .reg_value, .io_value, .flag_register, .jump_offset,
  .next_is_two_word, .pc, .taken, .busy, .done);

// [test/skip_branch_control_tb_top.sv]
// self-checking bench for the skip and jump control block
`timescale 1ns/1ps
module skip_branch_control_tb_top;
  reg core_clk = 1'b0;
  reg rstn = 1'b0;
  reg op_valid = 1'b0;
  reg [4:0] op_sel = 5'h00;
  reg [2:0] bit_index = 3'h0;
  reg [7:0] opnd = 8'h00;
  reg [6:0] jump_offset = 7'h00;
  reg next_is_two_word = 1'b0;
  wire [15:0] pc;
  wire taken, busy, done;
  reg [15:0] epc = 16'h0000;
  integer err_count = 0;
  integer n_tests = 0;
  integer cyc = 0;
  // flag values that make ops 07..11 jump, op 07 lowest
  localparam [87:0] TV = 88'h00_20_0C_00_04_01_00_00_01_00_02;
  always #25 core_clk = ~core_clk;
  skip_branch_control uut (.core_clk, .rstn, .op_valid, .op_sel, .bit_index,
    .reg_value(opnd), .io_value(opnd), .flag_register(opnd), .jump_offset,
    .next_is_two_word, .pc, .taken, .busy, .done);
  task chk(input [15:0] seen, input [15:0] exp, input [79:0] what);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("mismatch %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  // present one op, judge taken and pc, then wait for done
  task issue(input [4:0] op, input [2:0] bi, input [7:0] v, input [6:0] off, input tw,
    input tk, input [15:0] step);
    integer k;
    reg [15:0] ek;
    begin
      @(posedge core_clk);
      op_valid <= 1'b1;
      op_sel <= op;
      bit_index <= bi;
      opnd <= v;
      jump_offset <= off;
      next_is_two_word <= tw;
      @(posedge core_clk);
      op_valid <= 1'b0;
      #1;
      epc = epc + step;
      chk(taken, tk, "taken");
      chk(busy, tk, "busy");
      chk(pc, epc, "pc");
      // extra cycles: two for a long skip, one for other taken ops
      ek = (tk && tw && op < 5'h05) ? 16'h0002 : (tk ? 16'h0001 : 16'h0000);
      k = 0;
      while (done !== 1'b1 && k < 4) begin
        @(posedge core_clk);
        #1;
        k = k + 1;
      end
      chk(done, 1'b1, "done");
      chk(k[15:0], ek, "cycles");
      @(posedge core_clk);
      #1;
      chk(done, 1'b0, "done pulse");
      chk(taken, 1'b0, "taken end");
    end
  endtask
  // skips over short and long followers, and one not taken
  task t_skips;
    begin
      issue(5'h01, 3'h7, 8'h7F, 7'h00, 1'b0, 1'b1, 16'h0002);
      issue(5'h02, 3'h0, 8'h01, 7'h00, 1'b1, 1'b1, 16'h0003);
      issue(5'h03, 3'h3, 8'h08, 7'h00, 1'b1, 1'b0, 16'h0001);
      issue(5'h03, 3'h4, 8'hEF, 7'h00, 1'b0, 1'b1, 16'h0002);
      issue(5'h00, 3'h0, 8'h00, 7'h00, 1'b0, 1'b0, 16'h0001);
      issue(5'h04, 3'h6, 8'h40, 7'h00, 1'b1, 1'b1, 16'h0003);
    end
  endtask
  // indexed flag jumps, backward offsets included
  task t_index;
    begin
      issue(5'h05, 3'h5, 8'h20, 7'h7F, 1'b0, 1'b1, 16'h0000);
      issue(5'h06, 3'h3, 8'hF7, 7'h40, 1'b0, 1'b1, 16'hFFC1);
      issue(5'h05, 3'h2, 8'hFB, 7'h10, 1'b0, 1'b0, 16'h0001);
      issue(5'h06, 3'h1, 8'h02, 7'h10, 1'b0, 1'b0, 16'h0001);
    end
  endtask
  // every named-flag jump, taken then not taken
  task t_named;
    integer o;
    reg [7:0] v;
    begin
      for (o = 7; o < 18; o = o + 1) begin
        v = TV[(o - 7) * 8 +: 8];
        issue(o[4:0], 3'h0, v, 7'h05, 1'b0, 1'b1, 16'h0006);
        if (o != 15) issue(o[4:0], 3'h0, ~v, 7'h05, 1'b0, 1'b0, 16'h0001);
      end
      issue(5'h0F, 3'h0, 8'h04, 7'h05, 1'b0, 1'b0, 16'h0001);
    end
  endtask
  task end_of_test;
    begin
      if (err_count == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  // hang guard
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      err_count = err_count + 1;
      end_of_test;
    end
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    chk(pc, 16'h0000, "rst pc");
    t_skips;
    t_index;
    t_named;
    end_of_test;
  end
endmodule
